// file: design/iae_defs.vh
// Behaviour
// - edge mode reg 1 field picks input-3 edge: 00 fall, 01 rise, 11 both
// - edge mode reg 1 is 8 bits and resets to 00H, falling edge default
// - status word holds global enable; byte access plus enable/disable instructions
// - status word resets to 02H
// - any vectored acceptance pushes status word and clears global enable
// - non-maskable request ignores enable and masks and beats all others
// - non-maskable acceptance pushes status word then PC, clears enable, loads vector
// - a non-maskable request during non-maskable service is still accepted
// - maskable request eligible only with flag 1, mask 0, global enable 1
// - maskable request to service start takes 9 to 19 CPU clocks
// - simultaneous eligible maskable requests: highest fixed priority accepted first
// - requests not yet acceptable stay pending until conditions allow
// - maskable acceptance pushes status word then PC, clears enable, loads own vector
// - flag set before the final clock: acceptance right after that instruction
// - flag set in the final clock: next instruction runs before acceptance
// - after request or mask register access, hold all requests one more instruction
// - without re-enable in a routine, new maskable requests wait; no maskable nesting
// - request flag set on request, cleared on acceptance or reset
// - mask registers reset to FFH, all maskable sources disabled
// - priority 0 highest through 15 lowest
`ifndef IAE_DEFS_VH
`define IAE_DEFS_VH

// =====================================================
// register addresses
`define IAE_ADDR_EDGE_MODE1 16'hFFED
`define IAE_ADDR_REQ0 16'hFFE0
`define IAE_ADDR_REQ1 16'hFFE1
`define IAE_ADDR_MASK0 16'hFFE4
`define IAE_ADDR_MASK1 16'hFFE5

// =====================================================
// reset values and fields
`define IAE_EDGE_MODE1_RST 2'h0
`define IAE_PSW_RST 8'h02
`define IAE_REQ_RST 16'h0000
`define IAE_MASK_RST 16'hFFFF
`define IAE_IRQ_EN_BIT 1
`define IAE_EDGE_FALL 2'h0
`define IAE_EDGE_RISE 2'h1
`define IAE_EDGE_BOTH 2'h3
`define IAE_EXT3_SRC 4

// =====================================================
// vectors and timing
`define IAE_NMI_VECTOR 16'h0004
`define IAE_VEC_BASE 16'h0004
`define IAE_ACK_WAIT 4'h4

`endif

// file: design/iae_interrupt_accept.v
`timescale 1ns/1ns
`include "iae_defs.vh"

module iae_interrupt_accept #(
  parameter NUM_SRC = 16,
  parameter [3:0] ACK_WAIT = `IAE_ACK_WAIT,
  parameter [15:0] NMI_VECTOR = `IAE_NMI_VECTOR
) (
  input wire clk, // cpu clock
  input wire reset_n, // synchronous reset
  input wire [15:0] busAddr, // memory access address
  input wire busWrEn, // byte write strobe
  input wire busRdEn, // byte read strobe
  input wire [7:0] busWrData, // write byte
  output reg [7:0] busRdData, // read byte, valid cycle after strobe
  input wire [7:0] pswWrData, // status word byte from cpu
  input wire pswWrEn, // status word write strobe
  input wire irqOnInstr, // enable instruction executed
  input wire irqOffInstr, // disable instruction executed
  output reg [7:0] pswOut, // current status word
  input wire instrDone, // final clock of current instruction
  input wire [NUM_SRC-1:0] irqSrc, // internal request pulses, bit 4 unused
  input wire nmiReq, // non-maskable request pulse
  input wire externalIrqInput3, // external interrupt pin 3
  output reg cpuHold, // acceptance sequence owns the cpu
  output reg stackPush, // push one item
  output reg stackPushPc, // 0 status word, 1 program counter
  output reg [7:0] pushData, // status word being pushed
  output reg vectorLoad, // load pc from vectorAddr
  output reg [15:0] vectorAddr, // vector table entry address
  output reg ackNmi // acceptance was non-maskable
);

  // =====================================================
  // states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_PSW = 3'h2;
  localparam [2:0] ST_PC = 3'h3;
  localparam [2:0] ST_VEC = 3'h4;

  // =====================================================
  // registers
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] waitCnt_q;
  reg [1:0] edgeSel_q;
  reg [7:0] psw_q;
  reg [7:0] psw_d;
  reg [NUM_SRC-1:0] req_q;
  reg [NUM_SRC-1:0] req_d;
  reg [NUM_SRC-1:0] mask_q;
  reg [NUM_SRC-1:0] mask_d;
  reg nmiPend_q;
  reg hold_q;
  reg pin3_q;
  reg [3:0] ackIdx_q;
  reg ackIsNmi_q;
  reg [3:0] prioIdx;
  reg prioHit;
  reg edge3;
  reg [NUM_SRC-1:0] srcSet;
  integer i;

  // =====================================================
  // register decode and acceptance gating
  wire wrReq0 = busWrEn && (busAddr == `IAE_ADDR_REQ0);
  wire wrReq1 = busWrEn && (busAddr == `IAE_ADDR_REQ1);
  wire wrMask0 = busWrEn && (busAddr == `IAE_ADDR_MASK0);
  wire wrMask1 = busWrEn && (busAddr == `IAE_ADDR_MASK1);
  wire wrEdge = busWrEn && (busAddr == `IAE_ADDR_EDGE_MODE1);
  wire accReq = (busAddr == `IAE_ADDR_REQ0) || (busAddr == `IAE_ADDR_REQ1);
  wire accMask = (busAddr == `IAE_ADDR_MASK0) || (busAddr == `IAE_ADDR_MASK1);
  // reads count as manipulation too: bit tests of the flags also hold requests
  wire flagAccess = (busWrEn || busRdEn) && (accReq || accMask);
  wire blockNow = hold_q || flagAccess;
  wire irqEnBit = psw_q[`IAE_IRQ_EN_BIT];
  wire [NUM_SRC-1:0] elig = req_q & ~mask_q & {NUM_SRC{irqEnBit}};
  wire idle = (state_q == ST_IDLE);
  // flags are sampled as registered, so a flag set on the final clock misses
  wire acceptNmi = idle && instrDone && nmiPend_q && !blockNow;
  wire acceptMsk = idle && instrDone && !nmiPend_q && prioHit && !blockNow;
  wire accept = acceptNmi || acceptMsk;

  // =====================================================
  // edge detection on input 3
  always @*
  begin
    case (edgeSel_q)
      `IAE_EDGE_FALL: edge3 = pin3_q && !externalIrqInput3;
      `IAE_EDGE_RISE: edge3 = !pin3_q && externalIrqInput3;
      `IAE_EDGE_BOTH: edge3 = pin3_q != externalIrqInput3;
      // forbidden code detects nothing rather than guessing
      default: edge3 = 1'b0;
    endcase
  end

  always @*
  begin
    srcSet = irqSrc;
    srcSet[`IAE_EXT3_SRC] = edge3;
  end

  // =====================================================
  // fixed priority, lowest index wins
  always @*
  begin
    prioHit = 1'b0;
    prioIdx = 4'h0;
    // scan downward so the lowest eligible index is written last
    for (i = NUM_SRC - 1; i >= 0; i = i - 1)
    begin
      if (elig[i])
      begin
        prioHit = 1'b1;
        prioIdx = i[3:0];
      end
    end
  end

  // =====================================================
  // request and mask flags
  always @*
  begin
    req_d = req_q;
    if (wrReq0)
    begin
      req_d[7:0] = busWrData;
    end
    if (wrReq1)
    begin
      req_d[15:8] = busWrData;
    end
    if (acceptMsk)
    begin
      req_d[prioIdx] = 1'b0;
    end
    // set wins over clear so no request is lost; unaccepted flags persist
    req_d = req_d | srcSet;
  end

  always @*
  begin
    mask_d = mask_q;
    if (wrMask0)
    begin
      mask_d[7:0] = busWrData;
    end
    if (wrMask1)
    begin
      mask_d[15:8] = busWrData;
    end
  end

  // =====================================================
  // status word
  always @*
  begin
    psw_d = psw_q;
    // byte write also carries bit operations and the return restore
    if (pswWrEn)
    begin
      psw_d = pswWrData;
    end
    if (irqOnInstr)
    begin
      psw_d[`IAE_IRQ_EN_BIT] = 1'b1;
    end
    if (irqOffInstr)
    begin
      psw_d[`IAE_IRQ_EN_BIT] = 1'b0;
    end
    if (accept)
    begin
      // no maskable nesting until the routine re-enables
      psw_d[`IAE_IRQ_EN_BIT] = 1'b0;
    end
  end

  // =====================================================
  // acceptance sequence
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_WAIT;
        end
      end
      // fixed wind-down before the pushes, part of the service latency
      ST_WAIT:
      begin
        if (waitCnt_q == 4'h0)
        begin
          state_d = ST_PSW;
        end
      end
      ST_PSW: state_d = ST_PC;
      ST_PC: state_d = ST_VEC;
      ST_VEC: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      waitCnt_q <= 4'h0;
      edgeSel_q <= `IAE_EDGE_MODE1_RST;
      psw_q <= `IAE_PSW_RST;
      req_q <= `IAE_REQ_RST;
      mask_q <= `IAE_MASK_RST;
      nmiPend_q <= 1'b0;
      hold_q <= 1'b0;
      // pin history follows the pin in reset so no false edge follows it
      pin3_q <= externalIrqInput3;
      ackIdx_q <= 4'h0;
      ackIsNmi_q <= 1'b0;
      busRdData <= 8'h00;
      pswOut <= `IAE_PSW_RST;
      cpuHold <= 1'b0;
      stackPush <= 1'b0;
      stackPushPc <= 1'b0;
      pushData <= 8'h00;
      vectorLoad <= 1'b0;
      vectorAddr <= 16'h0000;
      ackNmi <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      psw_q <= psw_d;
      pswOut <= psw_d;
      req_q <= req_d;
      mask_q <= mask_d;
      pin3_q <= externalIrqInput3;
      // set wins so a pulse in the accept cycle is not lost
      nmiPend_q <= nmiReq || (nmiPend_q && !acceptNmi);
      if (wrEdge)
      begin
        // upper bits are expected zero and are not stored
        edgeSel_q <= busWrData[1:0];
      end
      if (instrDone && idle)
      begin
        // hold lasts through the instruction after the access
        hold_q <= flagAccess;
      end
      else if (flagAccess)
      begin
        hold_q <= 1'b1;
      end
      if (accept)
      begin
        waitCnt_q <= ACK_WAIT - 4'h1;
        ackIdx_q <= prioIdx;
        ackIsNmi_q <= acceptNmi;
        pushData <= psw_q;
      end
      else if (waitCnt_q != 4'h0)
      begin
        waitCnt_q <= waitCnt_q - 4'h1;
      end
      // read data stands one cycle; the idle bus reads zero
      busRdData <= 8'h00;
      if (busRdEn)
      begin
        case (busAddr)
          `IAE_ADDR_EDGE_MODE1: busRdData <= {6'h00, edgeSel_q};
          `IAE_ADDR_REQ0: busRdData <= req_q[7:0];
          `IAE_ADDR_REQ1: busRdData <= req_q[15:8];
          `IAE_ADDR_MASK0: busRdData <= mask_q[7:0];
          `IAE_ADDR_MASK1: busRdData <= mask_q[15:8];
          default: busRdData <= 8'h00;
        endcase
      end
      // outputs follow the next state so they line up with it
      cpuHold <= (state_d != ST_IDLE);
      stackPush <= (state_d == ST_PSW) || (state_d == ST_PC);
      stackPushPc <= (state_d == ST_PC);
      vectorLoad <= (state_d == ST_VEC);
      if (state_d == ST_VEC)
      begin
        ackNmi <= ackIsNmi_q;
        if (ackIsNmi_q)
        begin
          vectorAddr <= NMI_VECTOR;
        end
        else
        begin
          // two bytes per vector entry
          vectorAddr <= `IAE_VEC_BASE + {11'h000, ackIdx_q, 1'b0};
        end
      end
    end
  end

endmodule

// file: tb/iae_cpu_model.sv
`timescale 1ns/1ns
module iae_cpu_model #(
  parameter LEN = 4
) (
  input wire clk, // cpu clock
  input wire reset_n, // sync reset
  input wire cpuHold, // acceptance owns cpu
  output reg instrDone // final instruction clock
);
  localparam [3:0] LAST = LEN[3:0] - 4'h1;
  reg [3:0] cnt_q;
  // =====================================
  // instruction stream
  // stalls while the acceptance sequence runs
  always @(posedge clk)
  begin
    if (!reset_n || cpuHold)
    begin
      cnt_q <= 4'h0;
      instrDone <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == LAST) ? 4'h0 : cnt_q + 4'h1;
      instrDone <= (cnt_q == LAST - 4'h1);
    end
  end
endmodule

// file: tb/iae_checker_properties.sv
`timescale 1ns/1ns
module iae_checker #(
  parameter [15:0] NMI_VECTOR = 16'h0004
) (
  input wire clk, // cpu clock
  input wire reset_n, // sync reset
  input wire [15:0] busAddr, // address
  input wire busRdEn, // read strobe
  input wire [7:0] busRdData, // read byte
  input wire pswWrEn, // psw write
  input wire irqOnInstr, // enable instr
  input wire irqOffInstr, // disable instr
  input wire instrDone, // instr end
  input wire [7:0] pswOut, // status word
  input wire cpuHold, // acceptance busy
  input wire stackPush, // push pulse
  input wire stackPushPc, // pc push
  input wire vectorLoad, // load pulse
  input wire [15:0] vectorAddr, // vector
  input wire ackNmi // nmi accepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // =====================================
  // acceptance sequence, edge mode read and enable/disable instructions
  push_order_a: assert property (
    stackPush && !stackPushPc |=> stackPush && stackPushPc)
    else $error("pc push missing after psw push");
  vector_after_a: assert property (
    stackPush && stackPushPc |=> vectorLoad && cpuHold)
    else $error("vector load missing after pc push");
  hold_release_a: assert property (vectorLoad |=> !cpuHold)
    else $error("hold not released after vector");
  accept_edge_a: assert property ($rose(cpuHold) |-> $past(instrDone))
    else $error("acceptance not at instruction end");
  clears_enable_a: assert property ($rose(cpuHold) |-> !pswOut[1])
    else $error("enable still set after acceptance");
  hold_wait_a: assert property ($rose(cpuHold) |-> !stackPush [*4] ##1 stackPush)
    else $error("psw push at wrong cycle");
  nmi_vector_a: assert property (vectorLoad && ackNmi |-> vectorAddr == NMI_VECTOR)
    else $error("wrong nmi vector");
  own_vector_a: assert property (
    vectorLoad && !ackNmi |->
    vectorAddr >= 16'h0004 && vectorAddr <= 16'h0022 && !vectorAddr[0])
    else $error("maskable vector out of table");
  edge_read_a: assert property (
    busRdEn && busAddr == 16'hFFED |=> busRdData[7:2] == 6'h00)
    else $error("edge mode upper bits not zero");
  enable_set_a: assert property (
    irqOnInstr && !irqOffInstr && !pswWrEn && !instrDone |=> pswOut[1])
    else $error("enable instr did not set enable");
  disable_clr_a: assert property (
    irqOffInstr && !irqOnInstr && !pswWrEn |=> !pswOut[1])
    else $error("disable instr did not clear enable");
endmodule
bind iae_interrupt_accept iae_checker #(.NMI_VECTOR(NMI_VECTOR)) i_iae_checker (
  .clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busRdEn(busRdEn),
  .busRdData(busRdData), .pswWrEn(pswWrEn), .irqOnInstr(irqOnInstr),
  .irqOffInstr(irqOffInstr), .instrDone(instrDone), .pswOut(pswOut), .cpuHold(cpuHold),
  .stackPush(stackPush), .stackPushPc(stackPushPc), .vectorLoad(vectorLoad),
  .vectorAddr(vectorAddr), .ackNmi(ackNmi));

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam [15:0] NMIV = 16'h0004;
  reg clk = 0, reset_n = 0, busWrEn = 0, busRdEn = 0, pswWrEn = 0, pin = 1;
  reg irqOnInstr = 0, irqOffInstr = 0, nmiReq = 0;
  reg [15:0] busAddr = 16'h0000, irqSrc = 16'h0000;
  reg [7:0] busWrData = 8'h00, pswWrData = 8'h00, lastPush = 8'h00;
  wire [7:0] busRdData, pswOut, pushData;
  wire [15:0] vectorAddr;
  wire instrDone, cpuHold, stackPush, stackPushPc, vectorLoad, ackNmi;
  integer failures = 0, compares = 0, nVec = 0, nv, i;
  always #5 clk = ~clk;
  always @(posedge clk) if (vectorLoad === 1'b1) nVec <= nVec + 1;
  always @(negedge clk) if (stackPush && !stackPushPc) lastPush <= pushData;
  iae_interrupt_accept #(.NMI_VECTOR(NMIV)) i_iae_interrupt_accept (
    .clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData),
    .pswWrData(pswWrData), .pswWrEn(pswWrEn), .irqOnInstr(irqOnInstr),
    .irqOffInstr(irqOffInstr), .pswOut(pswOut), .instrDone(instrDone), .irqSrc(irqSrc),
    .nmiReq(nmiReq), .externalIrqInput3(pin), .cpuHold(cpuHold), .stackPush(stackPush),
    .stackPushPc(stackPushPc), .pushData(pushData), .vectorLoad(vectorLoad),
    .vectorAddr(vectorAddr), .ackNmi(ackNmi));
  iae_cpu_model i_iae_cpu_model (.clk(clk), .reset_n(reset_n), .cpuHold(cpuHold),
    .instrDone(instrDone));
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
  begin
    busAddr = a;
    busWrData = d;
    busWrEn = 1;
    @(negedge clk);
    busWrEn = 0;
    @(negedge clk);
  end
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    busAddr = a;
    busRdEn = 1;
    @(negedge clk);
    busRdEn = 0;
    chk("busRdData", {8'h00, e}, {8'h00, busRdData});
    @(negedge clk);
  end
  endtask
  task vec(input [15:0] e, input n);
    integer k;
  begin
    k = 0;
    while (vectorLoad !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k = k + 1;
    end
    chk("vectorLoad", 16'h0001, {15'h0, vectorLoad});
    chk("vectorAddr", e, vectorAddr);
    chk("ackNmi", {15'h0, n}, {15'h0, ackNmi});
    @(negedge clk);
  end
  endtask
  task report_and_stop;
  begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    failures = failures + 1;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n = 1;
    chk("pswOut", 16'h0002, {8'h00, pswOut});
    rd(16'hFFED, 8'h00);
    rd(16'hFFE4, 8'hFF);
    rd(16'hFFE5, 8'hFF);
    rd(16'hFFE0, 8'h00);
    rd(16'hFFE1, 8'h00);
    rd(16'hFFF0, 8'h00);
    // every edge code, input kept masked; input 3 is request bit 4
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(16'hFFED, i[7:0]);
      rd(16'hFFED, i[7:0]);
      wr(16'hFFE0, 8'h00);
      pin = 0;
      repeat (3) @(negedge clk);
      rd(16'hFFE0, (i == 0 || i == 3) ? 8'h10 : 8'h00);
      wr(16'hFFE0, 8'h00);
      pin = 1;
      repeat (3) @(negedge clk);
      rd(16'hFFE0, (i == 1 || i == 3) ? 8'h10 : 8'h00);
    end
    wr(16'hFFE0, 8'h00);
    wr(16'hFFE4, 8'hD3);
    irqSrc = 16'h0024;
    @(negedge clk);
    irqSrc = 16'h0000;
    vec(16'h0008, 1'b0);
    chk("pushData", 16'h0002, {14'h0, lastPush[1], 1'b0});
    chk("pswOut", 16'h0000, {15'h0, pswOut[1]});
    nv = nVec;
    irqSrc = 16'h0008;
    @(negedge clk);
    irqSrc = 16'h0000;
    repeat (40) @(negedge clk);
    chk("nesting", nv, nVec);
    // status restore as the return instruction does it
    pswWrData = 8'h02;
    pswWrEn = 1;
    @(negedge clk);
    pswWrEn = 0;
    vec(16'h000A, 1'b0);
    irqOnInstr = 1;
    @(negedge clk);
    irqOnInstr = 0;
    vec(16'h000E, 1'b0);
    irqOnInstr = 1;
    @(negedge clk);
    irqOnInstr = 0;
    chk("pswOut", 16'h0002, {14'h0, pswOut[1], 1'b0});
    irqOffInstr = 1;
    @(negedge clk);
    irqOffInstr = 0;
    chk("pswOut", 16'h0000, {15'h0, pswOut[1]});
    for (i = 0; i < 2; i = i + 1)
    begin
      nmiReq = 1;
      @(negedge clk);
      nmiReq = 0;
      vec(NMIV, 1'b1);
    end
    wr(16'hFFE0, 8'h00);
    wr(16'hFFE4, 8'hEF);
    irqOnInstr = 1;
    @(negedge clk);
    irqOnInstr = 0;
    pin = 0;
    vec(16'h000C, 1'b0);
    report_and_stop;
  end
endmodule
